// File: src/sffr_regs.vh
`ifndef SFFR_REGS_VH
`define SFFR_REGS_VH

// register byte addresses, one aligned 32-bit word each
`define SFFR_ADDR_W              16
`define SFFR_OFS_FLAG_SEL_AB     16'hE600
`define SFFR_OFS_FIFO_RESET      16'hE604
`define SFFR_OFS_FLAG_SEL_CD     16'hE608
`define SFFR_OFS_PIN_POLARITY    16'hE60C
`define SFFR_OFS_PORT_A_CFG      16'hE610
`define SFFR_OFS_STATUS          16'hE614

// reset values
`define SFFR_RST_FLAG_SEL        8'h00
`define SFFR_RST_PIN_POLARITY    2'h0
`define SFFR_RST_PORT_A_CFG      1'h0

// fifo_reset_control fields
`define SFFR_RST_NAK_BIT         7
`define SFFR_RST_EP_HI           3
`define SFFR_RST_EP_LO           0

// fifo_pin_polarity fields
`define SFFR_POL_EMPTY_BIT       1
`define SFFR_POL_FULL_BIT        0

// port_a_config field
`define SFFR_PA_CFG_BIT7         7

// status word fields
`define SFFR_STAT_FLAGS_HI       3
`define SFFR_STAT_FLAGS_LO       0
`define SFFR_STAT_NAK_BIT        4
`define SFFR_STAT_ADDR_HI        6
`define SFFR_STAT_ADDR_LO        5

// flag_source_select codes
`define SFFR_SEL_DEFAULT         4'h0
`define SFFR_SEL_GRP_LEVEL       2'h1
`define SFFR_SEL_GRP_EMPTY       2'h2
`define SFFR_SEL_GRP_FULL        2'h3

// endpoint numbers accepted by reset_endpoint_number
`define SFFR_EP_TWO              4'h2
`define SFFR_EP_FOUR             4'h4
`define SFFR_EP_SIX              4'h6
`define SFFR_EP_EIGHT            4'h8

`endif

// File: src/sffr_flag_mux.v
`timescale 1ns/100ps
`include "sffr_regs.vh"

// combinational source selection for one flag pin; the caller registers it
module sffr_flag_mux #(
	parameter integer PIN_SLOT = 0
) (
	input  wire [3:0] flag_source_select,
	input  wire [1:0] fifo_addr,
	input  wire [3:0] level_flags,
	input  wire [3:0] full_flags,
	input  wire [3:0] empty_flags,
	input  wire       pol_full_high,
	input  wire       pol_empty_high,
	input  wire       fourth_use_level,
	input  wire       port_a_bit7,
	output reg        flag_pin
);

	// full and empty are active low unless their polarity bit is set
	function pin_level;
		input flag;
		input active_high;
		begin
			pin_level = active_high ? flag : ~flag;
		end
	endfunction

	always @*
	begin
		flag_pin = 1'b0;
		if (flag_source_select == `SFFR_SEL_DEFAULT)
		begin
			case (PIN_SLOT)
			0: flag_pin = level_flags[fifo_addr];
			1: flag_pin = pin_level(full_flags[fifo_addr], pol_full_high);
			2: flag_pin = pin_level(empty_flags[fifo_addr], pol_empty_high);
			default: flag_pin = fourth_use_level ? level_flags[0] : port_a_bit7;
			endcase
		end
		else
		begin
			// low two bits pick the endpoint, high two the flag kind
			case (flag_source_select[3:2])
			`SFFR_SEL_GRP_LEVEL: flag_pin = level_flags[flag_source_select[1:0]];
			`SFFR_SEL_GRP_EMPTY: flag_pin = pin_level(empty_flags[flag_source_select[1:0]], pol_empty_high);
			`SFFR_SEL_GRP_FULL:  flag_pin = pin_level(full_flags[flag_source_select[1:0]], pol_full_high);
			default:             flag_pin = 1'b0; // reserved codes drive low
			endcase
		end
	end

endmodule // sffr_flag_mux

// File: src/sffr_top.v
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
`include "sffr_regs.vh"

module sffr_top #(
	parameter NUM_EP = 4
) (
	input  wire                     clk_sys,
	input  wire                     reset_n,
	input  wire                     clk_en,
	input  wire [`SFFR_ADDR_W-1:0]  paddr,
	input  wire                     psel,
	input  wire                     penable,
	input  wire                     pwrite,
	input  wire [31:0]              pwdata,
	output reg  [31:0]              prdata,
	output reg                      pready,
	output reg                      pslverr,
	input  wire                     fifo_select_hi,
	input  wire                     fifo_select_lo,
	input  wire [NUM_EP-1:0]        ep_level_flag,
	input  wire [NUM_EP-1:0]        ep_full_flag,
	input  wire [NUM_EP-1:0]        ep_empty_flag,
	input  wire                     port_a_bit7,
	output reg                      flag_out_first,
	output reg                      flag_out_second,
	output reg                      flag_out_third,
	output reg                      flag_out_fourth,
	output reg                      host_nak_all,
	output reg  [NUM_EP-1:0]        ep_fifo_reset
);

	reg  [7:0]        flag_sel_ab_q;
	reg  [7:0]        flag_sel_cd_q;
	reg  [1:0]        pin_polarity_q;
	reg               port_a_cfg_q;
	wire [1:0]        fifo_addr;
	wire              setup_phase;
	wire              wr_commit;
	wire [NUM_EP-1:0] level_m;
	wire [NUM_EP-1:0] full_m;
	wire [NUM_EP-1:0] empty_m;
	wire [3:0]        pin_d;
	wire [15:0]       sel_all;
	reg  [31:0]       rd_d;
	reg               hit_d;
	reg  [NUM_EP-1:0] ep_reset_d;

	// endpoint number to one-hot reset strobe; other numbers reset nothing
	function [NUM_EP-1:0] ep_reset_decode;
		input [3:0] ep_num;
		begin
			ep_reset_decode = {NUM_EP{1'b0}};
			case (ep_num)
			`SFFR_EP_TWO:   ep_reset_decode[0] = 1'b1;
			`SFFR_EP_FOUR:  ep_reset_decode[1] = 1'b1;
			`SFFR_EP_SIX:   ep_reset_decode[2] = 1'b1;
			`SFFR_EP_EIGHT: ep_reset_decode[3] = 1'b1;
			default:        ep_reset_decode = {NUM_EP{1'b0}};
			endcase
		end
	endfunction

	// returns true for every mapped word address
	function addr_mapped;
		input [`SFFR_ADDR_W-1:0] addr;
		begin
			case (addr)
			`SFFR_OFS_FLAG_SEL_AB,
			`SFFR_OFS_FIFO_RESET,
			`SFFR_OFS_FLAG_SEL_CD,
			`SFFR_OFS_PIN_POLARITY,
			`SFFR_OFS_PORT_A_CFG,
			`SFFR_OFS_STATUS: addr_mapped = 1'b1;
			default:          addr_mapped = 1'b0;
			endcase
		end
	endfunction

	// hi pin is the upper bit: 00 ep2, 01 ep4, 10 ep6, 11 ep8
	assign fifo_addr = {fifo_select_hi, fifo_select_lo};

	// the answer is prepared in the setup cycle so that pready and prdata
	// leave flops; this costs nothing, the access phase still has no wait
	assign setup_phase = psel & ~penable & ~pready;
	assign wr_commit   = psel & penable & pready & pwrite;

	// a FIFO under reset shows default flags: not full, empty, below level
	assign level_m = ep_level_flag & ~ep_fifo_reset;
	assign full_m  = ep_full_flag  & ~ep_fifo_reset;
	assign empty_m = ep_empty_flag |  ep_fifo_reset;

	assign sel_all = {flag_sel_cd_q, flag_sel_ab_q};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_pin
			sffr_flag_mux #(
				.PIN_SLOT (gi)
			) u_mux (
				.flag_source_select (sel_all[gi*4 +: 4]),
				.fifo_addr          (fifo_addr),
				.level_flags        (level_m),
				.full_flags         (full_m),
				.empty_flags        (empty_m),
				.pol_full_high      (pin_polarity_q[`SFFR_POL_FULL_BIT]),
				.pol_empty_high     (pin_polarity_q[`SFFR_POL_EMPTY_BIT]),
				.fourth_use_level   (port_a_cfg_q),
				.port_a_bit7        (port_a_bit7),
				.flag_pin           (pin_d[gi])
			);
		end
	endgenerate

	// read data; the reset register is write-only and reads as zero
	always @*
	begin
		rd_d  = 32'h0000_0000;
		hit_d = addr_mapped(paddr);
		case (paddr)
		`SFFR_OFS_FLAG_SEL_AB:  rd_d[7:0] = flag_sel_ab_q;
		`SFFR_OFS_FLAG_SEL_CD:  rd_d[7:0] = flag_sel_cd_q;
		`SFFR_OFS_PIN_POLARITY: rd_d[1:0] = pin_polarity_q;
		`SFFR_OFS_PORT_A_CFG:   rd_d[`SFFR_PA_CFG_BIT7] = port_a_cfg_q;
		`SFFR_OFS_STATUS:
		begin
			rd_d[`SFFR_STAT_FLAGS_HI:`SFFR_STAT_FLAGS_LO] =
				{flag_out_fourth, flag_out_third, flag_out_second, flag_out_first};
			rd_d[`SFFR_STAT_NAK_BIT]                    = host_nak_all;
			rd_d[`SFFR_STAT_ADDR_HI:`SFFR_STAT_ADDR_LO] = fifo_addr;
		end
		default:                rd_d = 32'h0000_0000;
		endcase
	end

	// a reset strobe lasts exactly one enabled cycle per write
	always @*
	begin
		ep_reset_d = {NUM_EP{1'b0}};
		if (wr_commit && paddr == `SFFR_OFS_FIFO_RESET)
			ep_reset_d = ep_reset_decode(pwdata[`SFFR_RST_EP_HI:`SFFR_RST_EP_LO]);
	end

	// APB slave response
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else if (clk_en)
		begin
			pready <= setup_phase;
			if (setup_phase)
			begin
				pslverr <= ~hit_d;
				prdata  <= pwrite ? 32'h0000_0000 : rd_d;
			end
			else
			begin
				pslverr <= 1'b0;
				prdata  <= 32'h0000_0000;
			end
		end
	end

	// configuration registers; writes land only at the completing edge
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			flag_sel_ab_q  <= `SFFR_RST_FLAG_SEL;
			flag_sel_cd_q  <= `SFFR_RST_FLAG_SEL;
			pin_polarity_q <= `SFFR_RST_PIN_POLARITY;
			port_a_cfg_q   <= `SFFR_RST_PORT_A_CFG;
		end
		else if (clk_en && wr_commit)
		begin
			case (paddr)
			`SFFR_OFS_FLAG_SEL_AB:  flag_sel_ab_q  <= pwdata[7:0];
			`SFFR_OFS_FLAG_SEL_CD:  flag_sel_cd_q  <= pwdata[7:0];
			`SFFR_OFS_PIN_POLARITY: pin_polarity_q <= pwdata[1:0];
			`SFFR_OFS_PORT_A_CFG:   port_a_cfg_q   <= pwdata[`SFFR_PA_CFG_BIT7];
			default:                port_a_cfg_q   <= port_a_cfg_q;
			endcase
		end
	end

	// nak level holds between writes so firmware can walk the reset
	// sequence while the host is held off
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			host_nak_all  <= 1'b0;
			ep_fifo_reset <= {NUM_EP{1'b0}};
		end
		else if (clk_en)
		begin
			ep_fifo_reset <= ep_reset_d;
			if (wr_commit && paddr == `SFFR_OFS_FIFO_RESET)
				host_nak_all <= pwdata[`SFFR_RST_NAK_BIT];
		end
	end

	// flag pins: one register stage after any source or select change
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			flag_out_first  <= 1'b0;
			flag_out_second <= 1'b0;
			flag_out_third  <= 1'b0;
			flag_out_fourth <= 1'b0;
		end
		else if (clk_en)
		begin
			flag_out_first  <= pin_d[0];
			flag_out_second <= pin_d[1];
			flag_out_third  <= pin_d[2];
			flag_out_fourth <= pin_d[3];
		end
	end

endmodule // sffr_top

// File: dv/sffr_checker.sv
`timescale 1ns/100ps
`include "sffr_regs.vh"
module sffr_checker (
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic        clk_en,
	input wire logic [15:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        host_nak_all,
	input wire logic [3:0]  ep_fifo_reset
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	wire       wr_rst = clk_en && psel && penable && pready && pwrite && !pslverr && paddr == `SFFR_OFS_FIFO_RESET;
	wire [3:0] exp_rst = {pwdata[3:0] == 4'h8, pwdata[3:0] == 4'h6, pwdata[3:0] == 4'h4, pwdata[3:0] == 4'h2};
	sequence setup_s;
		psel && !penable && !pready && clk_en;
	endsequence
	sequence answer_s;
		pready ##1 !pready;
	endsequence
	AST_ANSWER: assert property (setup_s |=> answer_s) else $error("setup not answered in one cycle");
	AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0) else $error("error without answer");
	AST_IDLE: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
	AST_NAK: assert property (wr_rst |=> host_nak_all == $past(pwdata[7])) else $error("nak bit wrong");
	AST_EP: assert property (wr_rst |=> ep_fifo_reset == $past(exp_rst)) else $error("wrong fifo reset");
	AST_ONE: assert property ($onehot0(ep_fifo_reset)) else $error("several fifos reset");
	AST_PULSE: assert property (ep_fifo_reset != 4'h0 |=> ep_fifo_reset == 4'h0) else $error("reset pulse stuck");
	AST_HOLD: assert property (!wr_rst |=> $stable(host_nak_all)) else $error("nak changed alone");
endmodule // sffr_checker

// File: dv/sffr_fifo_master.sv
`timescale 1ns/100ps
// stands in for the external master; pins move only right after a rising edge
module sffr_fifo_master (
	input  wire logic       clk_sys,
	output reg              fifo_select_hi = 1'h0,
	output reg              fifo_select_lo = 1'h0,
	output reg  [3:0]       level = 4'h0,
	output reg  [3:0]       full = 4'h0,
	output reg  [3:0]       empty = 4'h0,
	output reg              gpio_bit7 = 1'h0
);
	task drive(input [1:0] a, input [3:0] l, input [3:0] f, input [3:0] e, input p);
		@(posedge clk_sys);
		{fifo_select_hi, fifo_select_lo} <= a;
		level <= l;
		full <= f;
		empty <= e;
		gpio_bit7 <= p;
	endtask
endmodule // sffr_fifo_master

// File: dv/sffr_tb_top.sv
`timescale 1ns/100ps
`include "sffr_regs.vh"
module sffr_tb_top;
	reg         clk_sys = 1'h0;
	reg         reset_n = 1'h0;
	reg  [15:0] paddr = 16'h0;
	reg         psel = 1'h0;
	reg         penable = 1'h0;
	reg         pwrite = 1'h0;
	reg  [31:0] pwdata = 32'h0;
	reg  [31:0] rd;
	reg         err;
	reg         clk_en = 1'h1;
	reg  [1:0]  pv;
	wire [31:0] prdata;
	wire        pready, pslverr, sel_hi, sel_lo, gpio7, f1, f2, f3, f4, nak;
	wire [3:0]  lvl, full, empty, ep_rst;
	integer     failures = 0;
	integer     check_count = 0;
	integer     i;
	always #12.5 clk_sys = ~clk_sys;
	sffr_top sffr_top_i (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fifo_select_hi(sel_hi), .fifo_select_lo(sel_lo), .ep_level_flag(lvl), .ep_full_flag(full),
		.ep_empty_flag(empty), .port_a_bit7(gpio7), .flag_out_first(f1), .flag_out_second(f2),
		.flag_out_third(f3), .flag_out_fourth(f4), .host_nak_all(nak), .ep_fifo_reset(ep_rst));
	sffr_fifo_master sffr_fifo_master_i (.clk_sys(clk_sys), .fifo_select_hi(sel_hi), .fifo_select_lo(sel_lo),
		.level(lvl), .full(full), .empty(empty), .gpio_bit7(gpio7));
	function logic exp_pin(input [3:0] c, input [1:0] pol);
		case (c[3:2])
			2'h1: exp_pin = lvl[c[1:0]];
			2'h2: exp_pin = empty[c[1:0]] ^ ~pol[1];
			2'h3: exp_pin = full[c[1:0]] ^ ~pol[0];
			default: exp_pin = 1'h0;
		endcase
	endfunction
	task close_out;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [31:0] act, input logic [31:0] exp);
		check_count++;
		if (act !== exp)
		begin
			failures++;
			$display("BAD t=%0t act=%h exp=%h", $time, act, exp);
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// the bound only guards against a hang, the slave answers far sooner
	task apb(input [15:0] a, input w, input [31:0] d);
		integer n;
		@(posedge clk_sys);
		psel <= 1'h1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (pready !== 1'h1 && n < 20);
		if (pready !== 1'h1)
		begin
			failures++;
			close_out;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	initial
	begin
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'h1;
		apb(`SFFR_OFS_FIFO_RESET, 1'h0, 32'h0);
		chk(rd, 32'h0);
		apb(16'hE700, 1'h0, 32'h0);
		chk(err, 1'h1);
		for (i = 0; i < 4; i++)
		begin
			sffr_fifo_master_i.drive(i[1:0], 4'h1 << i, 4'h1 << i, ~(4'h1 << i), i[0]);
			tick(1);
			chk({f4, f3, f2, f1}, {i[0], 3'h5});
		end
		// with the enable low the pins must keep the old FIFO's flags
		clk_en <= 1'h0;
		sffr_fifo_master_i.drive(2'h0, 4'h0, 4'hF, 4'hF, 1'h0);
		tick(3);
		chk({f4, f3, f2, f1}, 4'hD);
		clk_en <= 1'h1;
		tick(1);
		chk({f4, f3, f2, f1}, 4'h0);
		apb(`SFFR_OFS_PORT_A_CFG, 1'h1, 32'h80);
		apb(`SFFR_OFS_PORT_A_CFG, 1'h0, 32'h0);
		chk(rd, 32'h80);
		// level of endpoint 2 high, port bit low, so the fourth pin tells them apart
		sffr_fifo_master_i.drive(2'h0, 4'h5, 4'h3, 4'h9, 1'h0);
		tick(2);
		chk(f4, lvl[0]);
		for (i = 0; i < 32; i++)
		begin
			// polarity bits differ for some codes so that a swap shows
			pv = {i[4], i[4] ^ i[2]};
			apb(`SFFR_OFS_PIN_POLARITY, 1'h1, {30'h0, pv});
			apb(`SFFR_OFS_FLAG_SEL_AB, 1'h1, {24'h0, i[3:0], i[3:0]});
			apb(`SFFR_OFS_FLAG_SEL_CD, 1'h1, {24'h0, i[3:0], i[3:0]});
			tick(2);
			chk(f1, i[3:0] == 4'h0 ? lvl[0] : exp_pin(i[3:0], pv));
			chk(f2, exp_pin(i[3:0] == 4'h0 ? 4'hC : i[3:0], pv));
			chk(f3, exp_pin(i[3:0] == 4'h0 ? 4'h8 : i[3:0], pv));
			chk(f4, i[3:0] == 4'h0 ? lvl[0] : exp_pin(i[3:0], pv));
			apb(`SFFR_OFS_FLAG_SEL_CD, 1'h0, 32'h0);
			chk(rd, {24'h0, i[3:0], i[3:0]});
			apb(`SFFR_OFS_PIN_POLARITY, 1'h0, 32'h0);
			chk(rd, {30'h0, pv});
		end
		apb(`SFFR_OFS_FLAG_SEL_AB, 1'h1, 32'h0);
		apb(`SFFR_OFS_FLAG_SEL_CD, 1'h1, 32'h0);
		apb(`SFFR_OFS_PIN_POLARITY, 1'h1, 32'h0);
		apb(`SFFR_OFS_FIFO_RESET, 1'h1, 32'h80);
		tick(1);
		chk(nak, 1'h1);
		for (i = 2; i <= 8; i += 2)
		begin
			sffr_fifo_master_i.drive(i[2:1] - 2'h1, 4'hF, 4'hF, 4'h0, 1'h0);
			apb(`SFFR_OFS_FIFO_RESET, 1'h1, 32'h80 | i);
			#1;
			chk({nak, ep_rst}, {1'h1, 4'h1 << (i / 2 - 1)});
			tick(1);
			// the FIFO under reset reads below level, not full and empty
			chk({f3, f2, f1}, 3'h2);
			tick(1);
			chk({f3, f2, f1}, 3'h5);
		end
		// address 11, nak set, pins fourth..first 1101
		apb(`SFFR_OFS_STATUS, 1'h0, 32'h0);
		chk(rd, 32'h7D);
		apb(`SFFR_OFS_FIFO_RESET, 1'h1, 32'h0);
		tick(1);
		chk(nak, 1'h0);
		close_out;
	end
endmodule // sffr_tb_top
bind sffr_top sffr_checker sffr_checker_i (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .host_nak_all(host_nak_all), .ep_fifo_reset(ep_fifo_reset));
